// [rss_pkg.sv]
`default_nettype none
package rss_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int START_US = 100; // internal supply bring-up window
  localparam int START_CYC = (CLK_HZ / HZ_PER_MHZ) * START_US;
  localparam int CONFIG_US = 1100; // configuration load time
  localparam int CONFIG_CYC = (CLK_HZ / HZ_PER_MHZ) * CONFIG_US;
  localparam int MS_US = 1000; // one delay unit of the wait registers
  localparam int MS_CYC = (CLK_HZ / HZ_PER_MHZ) * MS_US;
  localparam int FAULT_MS = 500; // all-rails-off time after a start fault
  localparam int FAULT_CYC = FAULT_MS * MS_CYC;
  localparam int RES_OSC_DIV = 20; // resistor-set oscillator, 1 MHz tick
  localparam int NRAIL = 4;
  localparam int TW = 24; // timer width
  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE_MODE = 8'hD2;
  localparam logic [7:0] ADDR_RAIL_ORDER = 8'hD5;
  localparam logic [7:0] ADDR_DIVIDER = 8'hD7;
  localparam logic [7:0] ADDR_POST_WAIT = 8'hDC;
  localparam logic [7:0] ADDR_ON_OFF_WAIT = 8'hDD;
  localparam logic [7:0] ADDR_RAMP_RATE = 8'hDE;
  localparam logic [7:0] ADDR_STATUS = 8'hE0;
  localparam logic [7:0] RST_ENABLE_MODE = 8'h00;
  localparam logic [7:0] RST_RAIL_ORDER = 8'h00; // all rails in slot 0
  localparam logic [7:0] RST_DIVIDER = 8'h00; // divide by 1
  localparam logic [7:0] RST_POST_WAIT = 8'h01; // 1 ms
  localparam logic [7:0] RST_ON_OFF_WAIT = 8'h55; // 5 ms on, 5 ms off
  localparam logic [7:0] RST_RAMP_RATE = 8'h00; // analog ramp
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam logic [1:0] EN_MODE_GATE = 2'h2; // first pin gates all rails
  localparam int PG_DEP_BIT = 2;
  localparam int DCM_ONLY_BIT = 3;
  localparam int DIS_LSB = 4;
  localparam int DIGSS_BIT = 2;
  // ----------------------------------------------------------------
  // soft-start ramp
  // ----------------------------------------------------------------
  localparam int STEP_MV = 10;
  localparam int VREF_MV = 800;
  localparam logic [7:0] RAMP_TOP = 8'(VREF_MV / STEP_MV);
  localparam logic [4:0] LS_FULL = 5'h10; // low-side width at full sync
  localparam int STEP_US_BASE = 10; // step time doubles per rate code
  localparam int STEP_W = 12;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] enable_mode_config;
    logic [7:0] rail_order_config;
    logic [7:0] divider_phase_config;
    logic [7:0] post_config_wait;
    logic [7:0] rail_on_off_wait;
    logic [7:0] ramp_step_rate;
  } rss_cfg_t;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rss_reg_req_t;
  typedef enum logic [2:0] {
    ST_OFF, ST_START, ST_WAIT_RST, ST_CONFIG, ST_RDELAY, ST_SEQ, ST_RUN, ST_FAULT
  } rss_state_t;
  // cycles per digital ramp step for a rate code
  function automatic logic [STEP_W-1:0] step_cyc(input logic [1:0] sel);
    return STEP_W'(((CLK_HZ / HZ_PER_MHZ) * STEP_US_BASE) << sel);
  endfunction : step_cyc
endpackage : rss_pkg
`default_nettype wire

// [rss_sync.sv]
`default_nettype none
module rss_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // asynchronous inputs and filtered result
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import rss_pkg::*;
  logic [W-1:0] s1, s2, s3, next_dout;
  // a bit changes once the second and third stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
    end
  end
  // three-stage chain and filtered output
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : rss_sync
`default_nettype wire

// [rss_rail.sv]
`default_nettype none
module rss_rail (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic osc_tick,
  input wire logic [1:0] div_sel,
  input wire logic [1:0] rate_sel,
  input wire logic digital_ss,
  input wire logic dcm_only,
  input wire logic fb_above,
  // rail outputs
  output logic [7:0] ramp_code,
  output logic ramp_from_pin,
  output logic switching_on,
  output logic low_side_pulse,
  output logic [4:0] ls_width,
  output logic ccm_reached,
  output logic pwm_tick
);
  import rss_pkg::*;
  logic [2:0] div_cnt, next_div_cnt, div_mask;
  logic [rss_pkg::STEP_W-1:0] step_cnt, next_step_cnt;
  logic [7:0] next_ramp;
  logic next_from_pin, next_sw, next_ls_pulse, next_pwm, next_ccm;
  logic [4:0] next_ls;
  // divider, ramp and switching start
  always_comb begin
    div_mask = 3'((4'h1 << div_sel) - 4'h1);
    next_div_cnt = osc_tick ? 3'(div_cnt + 3'h1) : div_cnt;
    next_pwm = osc_tick && ((div_cnt & div_mask) == 3'h0);
    next_from_pin = !digital_ss;
    next_ramp = ramp_code;
    next_step_cnt = step_cnt;
    next_sw = switching_on;
    next_ls = ls_width;
    next_ls_pulse = 1'b0;
    if (!start) begin
      next_ramp = 8'h00;
      next_step_cnt = '0;
      next_sw = 1'b0;
      next_ls = 5'h00;
    end else begin
      if (digital_ss && ramp_code != RAMP_TOP) begin
        if (step_cnt >= step_cyc(rate_sel) - STEP_W'(1)) begin
          next_step_cnt = '0;
          next_ramp = 8'(ramp_code + 8'h01);
        end else begin
          next_step_cnt = STEP_W'(step_cnt + STEP_W'(1));
        end
      end
      if (!fb_above) begin
        next_sw = 1'b1;
      end
      if (switching_on && pwm_tick) begin
        next_ls_pulse = 1'b1;
        if (ls_width == 5'h00) begin
          next_ls = 5'h01;
        end else if (!dcm_only && ls_width != LS_FULL) begin
          next_ls = 5'(ls_width + 5'h01);
        end
      end
    end
    next_ccm = (next_ls == LS_FULL);
  end
  // registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= 3'h0;
      step_cnt <= '0;
      ramp_code <= 8'h00;
      ramp_from_pin <= 1'b1;
      switching_on <= 1'b0;
      low_side_pulse <= 1'b0;
      ls_width <= 5'h00;
      ccm_reached <= 1'b0;
      pwm_tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      step_cnt <= next_step_cnt;
      ramp_code <= next_ramp;
      ramp_from_pin <= next_from_pin;
      switching_on <= next_sw;
      low_side_pulse <= next_ls_pulse;
      ls_width <= next_ls;
      ccm_reached <= next_ccm;
      pwm_tick <= next_pwm;
    end
  end
  // checks
  a_ramp_step: assert property (@(posedge core_clk) disable iff (rst)
    start && $past(start) && ramp_code != $past(ramp_code)
    |-> ramp_code == 8'($past(ramp_code) + 8'h01))
    else $error("ramp moved by more than one step");
  a_hold_switch: assert property (@(posedge core_clk) disable iff (rst)
    (start && fb_above && !switching_on) |=> !switching_on)
    else $error("switching began above feedback");
  a_ls_grow: assert property (@(posedge core_clk) disable iff (rst)
    (start && switching_on && pwm_tick && !dcm_only && ls_width != 5'h00
     && ls_width != LS_FULL) |=> ls_width == 5'($past(ls_width) + 5'h01))
    else $error("low-side width did not grow");
endmodule : rss_rail
`default_nettype wire

// [rss_sequencer.sv]
`default_nettype none
// Function
// - bring up internal supplies before anything else
// - reset rise runs 1.1 ms configuration load
// - then wait programmable reset delay
// - any rail first, each waits on-delay
// - on and off delays default 5 ms
// - default order starts all rails together
// - good mode: prior good, then delay
// - fixed mode: delay counts from prior enable
// - disabled rails are skipped in order
// - no startup while input under lockout
// - enable mode 10: pin gates all rails
// - ramp from capacitor pin or digital
// - digital ramp steps 10 mV, rate selectable
// - ramp from zero, switch after crossing
// - first pulse low side, then diode emulation
// - continuous mode grows low-side pulse gradually
// - PWM rate is oscillator over 1,2,4,8
// - oscillator clock driven out on pin
// - no lock: fall back to resistor rate
// - reset delay defaults to 1 ms
// - start fault in non-default rail order: rails off 500 ms, restart
module rss_sequencer #(
  parameter int CONFIG_CYCLES = rss_pkg::CONFIG_CYC,
  parameter int MS_CYCLES = rss_pkg::MS_CYC,
  parameter int FAULT_CYCLES = rss_pkg::FAULT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins
  input wire logic chip_enable_pin,
  input wire logic reset_release_pin,
  input wire logic vin_ok_pin,
  input wire logic [3:0] rail_enable_pin,
  input wire logic [3:0] rail_good_output,
  input wire logic [3:0] rail_fault_pin,
  input wire logic [3:0] fb_above_pin,
  input wire logic osc_set_sync_pin,
  input wire logic sync_locked_pin,
  // nonvolatile image and management register port
  input wire rss_pkg::rss_cfg_t nvm_image,
  input wire rss_pkg::rss_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // startup status
  output logic int_supply_en,
  output logic config_busy,
  output logic [3:0] rail_start,
  output logic clk_out,
  // rail drive
  output logic [3:0][7:0] ramp_code,
  output logic [3:0] ramp_from_pin,
  output logic [3:0] switching_on,
  output logic [3:0] low_side_pulse,
  output logic [3:0] ccm_reached,
  output logic [3:0] pwm_tick
);
  import rss_pkg::*;
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [20:0] sync_out;
  logic ce_s, rstn_s, vin_s, osc_s, lock_s;
  logic [3:0] en_s, good_s, fault_s, fb_s;
  rss_sync #(.W(21)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din({chip_enable_pin, reset_release_pin, vin_ok_pin, rail_enable_pin,
          rail_good_output, rail_fault_pin, fb_above_pin, osc_set_sync_pin,
          sync_locked_pin}),
    .dout(sync_out)
  );
  assign {ce_s, rstn_s, vin_s, en_s, good_s, fault_s, fb_s, osc_s, lock_s} = sync_out;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rss_state_t state, next_state;
  rss_cfg_t cfg, next_cfg;
  logic [TW-1:0] timer, next_timer;
  logic [1:0] slot, next_slot;
  logic armed, next_armed;
  logic [3:0] run, next_run, last, next_last, slot_rails, pin_ok, next_start;
  logic [3:0] disabled;
  logic gate_mode, internal_seq, prev_ok, next_int_en, next_busy;
  logic [7:0] next_rdata;
  // converts a count of milliseconds to clock cycles
  function automatic logic [TW-1:0] ms_to_cyc(input logic [7:0] n);
    return TW'(int'(n) * MS_CYCLES);
  endfunction : ms_to_cyc
  // decoded configuration
  always_comb begin
    gate_mode = (cfg.enable_mode_config[1:0] == EN_MODE_GATE);
    disabled = cfg.enable_mode_config[DIS_LSB +: 4];
    internal_seq = (cfg.rail_order_config != RST_RAIL_ORDER);
    for (int i = 0; i < NRAIL; i++) begin
      slot_rails[i] = (cfg.rail_order_config[2*i +: 2] == slot) && !disabled[i];
      pin_ok[i] = gate_mode ? en_s[0] : en_s[i];
    end
    prev_ok = !cfg.enable_mode_config[PG_DEP_BIT] || (&(good_s | ~last));
  end
  // ----------------------------------------------------------------
  // sequencer and register file
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cfg = cfg;
    next_timer = (timer != '0) ? TW'(timer - TW'(1)) : timer;
    next_slot = slot;
    next_armed = armed;
    next_run = run;
    next_last = last;
    if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_ENABLE_MODE: next_cfg.enable_mode_config = reg_req.wdata;
        ADDR_RAIL_ORDER: next_cfg.rail_order_config = reg_req.wdata;
        ADDR_DIVIDER: next_cfg.divider_phase_config = reg_req.wdata;
        ADDR_POST_WAIT: next_cfg.post_config_wait = reg_req.wdata;
        ADDR_ON_OFF_WAIT: next_cfg.rail_on_off_wait = reg_req.wdata;
        ADDR_RAMP_RATE: next_cfg.ramp_step_rate = reg_req.wdata;
        default: next_cfg = cfg;
      endcase
    end
    case (state)
      ST_OFF: begin
        next_state = ST_START;
        next_timer = TW'(START_CYC);
      end
      ST_START: begin
        if (timer == '0) begin
          next_state = ST_WAIT_RST;
        end
      end
      ST_WAIT_RST: begin
        if (rstn_s) begin
          next_state = ST_CONFIG;
          next_timer = TW'(CONFIG_CYCLES);
        end
      end
      ST_CONFIG: begin
        if (timer == '0) begin
          next_cfg = nvm_image;
          next_state = ST_RDELAY;
          next_timer = ms_to_cyc(nvm_image.post_config_wait);
        end
      end
      ST_RDELAY: begin
        if (timer == '0) begin
          next_state = ST_SEQ;
          next_slot = 2'h0;
          next_armed = 1'b0;
          next_last = 4'h0;
        end
      end
      ST_SEQ: begin
        if (slot_rails == 4'h0) begin
          next_slot = 2'(slot + 2'h1);
          if (slot == 2'h3) begin
            next_state = ST_RUN;
          end
        end else if (!armed) begin
          if (prev_ok && !(gate_mode && !en_s[0])) begin
            next_armed = 1'b1;
            next_timer = ms_to_cyc({4'h0, cfg.rail_on_off_wait[3:0]});
          end
        end else if (timer == '0) begin
          next_run = run | slot_rails;
          next_last = slot_rails;
          next_armed = 1'b0;
          next_slot = 2'(slot + 2'h1);
          if (slot == 2'h3) begin
            next_state = ST_RUN;
          end
        end
        if (internal_seq && (fault_s & run) != 4'h0) begin
          next_state = ST_FAULT;
          next_run = 4'h0;
          next_timer = TW'(FAULT_CYCLES);
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      ST_FAULT: begin
        if (timer == '0) begin
          next_state = ST_START;
          next_timer = TW'(START_CYC);
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (!ce_s || !vin_s) begin
      next_state = ST_OFF;
      next_run = 4'h0;
      next_armed = 1'b0;
      next_timer = '0;
    end
    next_int_en = (next_state != ST_OFF);
    next_busy = (next_state == ST_CONFIG);
    next_start = next_run & pin_ok;
    case (reg_req.addr)
      ADDR_ENABLE_MODE: next_rdata = cfg.enable_mode_config;
      ADDR_RAIL_ORDER: next_rdata = cfg.rail_order_config;
      ADDR_DIVIDER: next_rdata = cfg.divider_phase_config;
      ADDR_POST_WAIT: next_rdata = cfg.post_config_wait;
      ADDR_ON_OFF_WAIT: next_rdata = cfg.rail_on_off_wait;
      ADDR_RAMP_RATE: next_rdata = cfg.ramp_step_rate;
      ADDR_STATUS: next_rdata = {1'b0, state, rail_start};
      default: next_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_OFF;
      cfg <= {RST_ENABLE_MODE, RST_RAIL_ORDER, RST_DIVIDER, RST_POST_WAIT,
              RST_ON_OFF_WAIT, RST_RAMP_RATE};
      timer <= '0;
      slot <= 2'h0;
      armed <= 1'b0;
      run <= 4'h0;
      last <= 4'h0;
      int_supply_en <= 1'b0;
      config_busy <= 1'b0;
      rail_start <= 4'h0;
      reg_rdata <= 8'h00;
    end else begin
      state <= next_state;
      cfg <= next_cfg;
      timer <= next_timer;
      slot <= next_slot;
      armed <= next_armed;
      run <= next_run;
      last <= next_last;
      int_supply_en <= next_int_en;
      config_busy <= next_busy;
      rail_start <= next_start;
      reg_rdata <= next_rdata;
    end
  end
  // ----------------------------------------------------------------
  // master oscillator tick and clock out
  // ----------------------------------------------------------------
  logic [4:0] osc_cnt, next_osc_cnt;
  logic osc_d, osc_tick, next_tick, next_clk_out;
  always_comb begin
    next_osc_cnt = (osc_cnt == 5'(RES_OSC_DIV - 1)) ? 5'h00 : 5'(osc_cnt + 5'h01);
    next_tick = lock_s ? (osc_s && !osc_d) : (osc_cnt == 5'h00);
    next_clk_out = osc_tick ? !clk_out : clk_out;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_cnt <= 5'h00;
      osc_d <= 1'b0;
      osc_tick <= 1'b0;
      clk_out <= 1'b0;
    end else begin
      osc_cnt <= next_osc_cnt;
      osc_d <= osc_s;
      osc_tick <= next_tick;
      clk_out <= next_clk_out;
    end
  end
  // ----------------------------------------------------------------
  // rails
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NRAIL; g++) begin : g_rail
    rss_rail u_rail (
      .core_clk(core_clk),
      .rst(rst),
      .start(rail_start[g]),
      .osc_tick(osc_tick),
      .div_sel(cfg.divider_phase_config[1:0]),
      .rate_sel(cfg.ramp_step_rate[1:0]),
      .digital_ss(cfg.ramp_step_rate[DIGSS_BIT]),
      .dcm_only(cfg.enable_mode_config[DCM_ONLY_BIT]),
      .fb_above(fb_s[g]),
      .ramp_code(ramp_code[g]),
      .ramp_from_pin(ramp_from_pin[g]),
      .switching_on(switching_on[g]),
      .low_side_pulse(low_side_pulse[g]),
      .ls_width(),
      .ccm_reached(ccm_reached[g]),
      .pwm_tick(pwm_tick[g])
    );
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [TW-1:0] cfg_len;
  always_ff @(posedge core_clk) begin
    if (rst || !config_busy) begin
      cfg_len <= '0;
    end else begin
      cfg_len <= TW'(cfg_len + TW'(1));
    end
  end
  a_supply_first: assert property (@(posedge core_clk) disable iff (rst)
    config_busy |-> int_supply_en)
    else $error("configuration ran without internal supplies");
  a_config_len: assert property (@(posedge core_clk) disable iff (rst)
    $fell(config_busy) && state == ST_RDELAY |-> $past(cfg_len) == TW'(CONFIG_CYCLES))
    else $error("configuration phase length wrong");
  a_delay_first: assert property (@(posedge core_clk) disable iff (rst)
    $rose(state == ST_SEQ) |-> $past(state) == ST_RDELAY)
    else $error("sequence began without reset delay");
  a_uvlo_block: assert property (@(posedge core_clk) disable iff (rst)
    !vin_s |=> ##1 rail_start == 4'h0)
    else $error("rail started under lockout");
  a_gate_mode: assert property (@(posedge core_clk) disable iff (rst)
    gate_mode && !en_s[0] |=> rail_start == 4'h0)
    else $error("rail started with sequence gate low");
  a_skip_off: assert property (@(posedge core_clk) disable iff (rst)
    (run & disabled & ~$past(run)) == 4'h0)
    else $error("disabled rail entered the order");
  a_fault_off: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_FAULT |=> rail_start == 4'h0)
    else $error("rails not off after start fault");
endmodule : rss_sequencer
`default_nettype wire

// [rss_rail_model.sv]
`default_nettype none
module rss_rail_model (
  // clock and device status
  input wire logic core_clk,
  input wire logic int_supply_en,
  input wire logic [3:0] rail_start,
  // comparator settling time in cycles
  input wire logic [31:0] good_lag,
  // pins toward the device
  output logic reset_release_pin,
  output logic [3:0] rail_good_output
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [4];
  initial {reset_release_pin, rail_good_output} = '0;
  // release reset while supplies still start, so config follows at once
  always @(posedge core_clk) reset_release_pin <= int_supply_en;
  // a rail reports good only a set time after it is started
  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] = rail_start[i] ? cnt[i] + 1 : 0;
      rail_good_output[i] <= rail_start[i] && cnt[i] > good_lag;
    end
  end
endmodule : rss_rail_model
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rss_pkg::*;
  logic core_clk = 0, rst = 1, ce = 1, vin = 1, osc = 0, locked = 0, co;
  logic [3:0] ren = 4'hF, fault = 4'h0, fb = 4'h0, good, rs, so, lsp, ccm, pwm, rfp;
  logic reset_pin, sup, busy, clk_out;
  logic [7:0] rdata;
  logic [3:0][7:0] ramp;
  logic [7:0] adr [7] = '{8'hD2, 8'hD5, 8'hD7, 8'hDC, 8'hDD, 8'hDE, 8'h10};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h55, 8'h00, 8'h00};
  rss_cfg_t nvm = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h55, 8'h00};
  rss_reg_req_t req = '0;
  int lag = 60, fail_count = 0, checks = 0, cyc = 1, t [10], p [2], c [2];
  // core clock and an unlocked sync clock that must be ignored
  always #25 core_clk = ~core_clk;
  always #170 osc = ~osc;
  rss_sequencer #(.CONFIG_CYCLES(50), .MS_CYCLES(20), .FAULT_CYCLES(100)) rss_sequencer_i (
    .core_clk(core_clk), .rst(rst), .chip_enable_pin(ce), .reset_release_pin(reset_pin),
    .vin_ok_pin(vin), .rail_enable_pin(ren), .rail_good_output(good), .rail_fault_pin(fault),
    .fb_above_pin(fb), .osc_set_sync_pin(osc), .sync_locked_pin(locked), .nvm_image(nvm),
    .reg_req(req), .reg_rdata(rdata), .int_supply_en(sup), .config_busy(busy),
    .rail_start(rs), .clk_out(clk_out), .ramp_code(ramp), .ramp_from_pin(rfp),
    .switching_on(so), .low_side_pulse(lsp), .ccm_reached(ccm), .pwm_tick(pwm));
  rss_rail_model rss_rail_model_i (.core_clk(core_clk), .int_supply_en(sup), .rail_start(rs),
    .good_lag(lag), .reset_release_pin(reset_pin), .rail_good_output(good));
  // cycle stamps of the edges that the tests measure
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    co <= clk_out;
    for (int i = 0; i < 4; i++) if (rs[i] && t[i] == 0) t[i] <= cyc;
    if (sup && t[4] == 0) t[4] <= cyc;
    if (busy && t[5] == 0) t[5] <= cyc;
    if (!busy && t[5] != 0 && t[6] == 0) t[6] <= cyc;
    if (ramp[2] == 8'h01 && t[7] == 0) t[7] <= cyc;
    if (ramp[2] == 8'h02 && t[8] == 0) t[8] <= cyc;
    if (lsp[2] && t[9] == 0) t[9] <= cyc;
    if (pwm[0]) p <= '{p[1], cyc};
    if (clk_out != co) c <= '{c[1], cyc};
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic win(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h1);
  endtask : win
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, a, d};
    tick(1);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req.addr = a;
    tick(2);
    check(rdata, e);
  endtask : rd
  // drop the input supply, load a new image, then start again
  task automatic boot(input rss_cfg_t cfg, input int n);
    vin = 0;
    tick(20);
    check(sup, 0);
    nvm = cfg;
    t = '{default: 0};
    vin = 1;
    tick(n);
  endtask : boot
  task automatic summarize;
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    summarize();
  end
  // startup with default image, then ordered, good-gated, fault and gate runs
  initial begin
    tick(6);
    rst = 0;
    tick(10);
    rd(ADDR_STATUS, 8'h10);
    foreach (adr[i]) rd(adr[i], rv[i]);
    wr(ADDR_RAIL_ORDER, 8'hA5);
    rd(ADDR_RAIL_ORDER, 8'hA5);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h10);
    tick(2300);
    win(t[5] - t[4], 2000, 2006);
    win(t[6] - t[5], 50, 51);
    win(t[0] - t[6], 120, 126);
    check(32'(t[1] == t[0] && t[2] == t[0] && t[3] == t[0]), 1);
    check(rfp, 4'hF);
    fb = 4'h1;
    boot('{8'h20, 8'hC9, 8'h00, 8'h00, 8'h51, 8'h05}, 2150);
    win(t[2] - t[6], 20, 24);
    win(t[0] - t[2], 20, 23);
    win(t[3] - t[0], 20, 24);
    check(t[1], 0);
    check(rfp, 4'h0);
    check(so[0], 0);
    fb = 4'h0;
    tick(10);
    check(so[0], 1);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_DIVIDER, 8'(k));
      rd(ADDR_DIVIDER, 8'(k));
      tick(400);
      check(p[1] - p[0], RES_OSC_DIV << k);
    end
    check(c[1] - c[0], RES_OSC_DIV);
    locked = 1;
    tick(60);
    win(c[1] - c[0], 6, 7);
    locked = 0;
    check(t[8] - t[7], 400);
    check(32'(t[9] > 0), 1);
    check(ccm[2], 1);
    boot('{8'h24, 8'h8D, 8'h00, 8'h00, 8'h51, 8'h00}, 2180);
    win(t[0] - t[2], 80, 92);
    fault = 4'h1;
    tick(8);
    rd(ADDR_STATUS, 8'h70);
    check(rs, 4'h0);
    fault = 4'h0;
    tick(110);
    rd(ADDR_STATUS, 8'h10);
    ren = 4'hE;
    boot('{8'h0A, 8'h00, 8'h00, 8'h00, 8'h51, 8'h00}, 2150);
    check(rs, 4'h0);
    ren = 4'h1;
    tick(30);
    check(rs, 4'hF);
    tick(400);
    check(ccm, 4'h0);
    summarize();
  end
endmodule : tb
`default_nettype wire
